// ==== ring_node_pkg.sv ====
package ring_node_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned MON_HALF_NS = 1000;
  localparam int unsigned MON_HALF_CYC = (MON_HALF_NS * CLK_MHZ) / 1000;
  localparam int unsigned LOSS_TIME_US = 100;
  localparam int unsigned LOSS_CYC = LOSS_TIME_US * CLK_MHZ;
  localparam int unsigned FLASH_TIME_MS = 250;
  localparam int unsigned FLASH_CYC = FLASH_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned GEN_PERIOD_US = 1000;
  localparam int unsigned GEN_PERIOD_CYC = GEN_PERIOD_US * CLK_MHZ;
  localparam int unsigned GEN_PULSE_US = 10;
  localparam int unsigned GEN_PULSE_CYC = GEN_PULSE_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0c;

  localparam int unsigned CTRL_W = 5;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam int unsigned CTRL_MASTER = 0;
  localparam int unsigned CTRL_SINGLE = 1;
  localparam int unsigned CTRL_LOOP = 2;
  localparam int unsigned CTRL_GEN = 3;
  localparam int unsigned CTRL_ALM_DIS = 4;

  localparam int unsigned STAT_W = 11;
  localparam int unsigned ST_WRAP_BAK = 0;
  localparam int unsigned ST_WRAP_PRI = 1;
  localparam int unsigned ST_LOSS_A = 2;
  localparam int unsigned ST_LOSS_B = 3;
  localparam int unsigned ST_LOOP_A = 4;
  localparam int unsigned ST_LOOP_B = 5;
  localparam int unsigned ST_ALARM = 6;
  localparam int unsigned ST_FAULT = 7;

  localparam int unsigned INT_W = 5;
  localparam logic [4:0] INT_RESET = 5'h00;
  localparam int unsigned INT_WRAP_BAK = 0;
  localparam int unsigned INT_WRAP_PRI = 1;
  localparam int unsigned INT_LOSS = 2;
  localparam int unsigned INT_LOOP_A = 3;
  localparam int unsigned INT_LOOP_B = 4;

  // ----------------------------------------------------------------
  // pin synchroniser slots
  // ----------------------------------------------------------------
  localparam int unsigned NSYNC = 8;
  localparam int unsigned PIN_HOST = 0;
  localparam int unsigned PIN_RTU = 1;
  localparam int unsigned PIN_RX_A = 2;
  localparam int unsigned PIN_RX_B = 3;
  localparam int unsigned PIN_SD_A = 4;
  localparam int unsigned PIN_SD_B = 5;
  localparam int unsigned PIN_MON_A = 6;
  localparam int unsigned PIN_MON_B = 7;
  localparam logic [7:0] SYNC_RESET = 8'h3f;

  typedef enum logic [3:0] {
    WRAP_NONE = 4'b0001,
    WRAP_TO_BAK = 4'b0010,
    WRAP_TO_PRI = 4'b0100,
    WRAP_ISO = 4'b1000
  } wrap_state_t;

endpackage

// ==== activity_watch.sv ====
`timescale 1ns/10ps
module activity_watch #(
  parameter int unsigned LIMIT = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sig,
  output logic alive
);
  localparam int unsigned CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIM = CW'(LIMIT);

  if (LIMIT < 2) begin : g_chk
    $error("activity_watch: LIMIT must be at least 2");
  end

  logic prev_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  wire toggled = sig ^ prev_q;

  assign cnt_d = toggled ? '0 : (cnt_q == LIM) ? cnt_q : cnt_q + 1'b1;
  assign alive = (cnt_q != LIM);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      prev_q <= sig;
      cnt_q <= cnt_d;
    end
  end
endmodule

// ==== ring_node.sv ====
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
module ring_node #(
  parameter int unsigned LOSS_CYCLES = ring_node_pkg::LOSS_CYC,
  parameter int unsigned FLASH_CYCLES = ring_node_pkg::FLASH_CYC,
  parameter int unsigned GEN_PERIOD = ring_node_pkg::GEN_PERIOD_CYC,
  parameter int unsigned GEN_PULSE = ring_node_pkg::GEN_PULSE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ring_node_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic host_rxd,
  output logic host_txd,
  input wire logic rtu_rxd,
  output logic rtu_txd,
  input wire logic opt_rx_a,
  input wire logic opt_rx_b,
  input wire logic sig_det_a,
  input wire logic sig_det_b,
  output logic opt_tx_a,
  output logic opt_tx_b,
  input wire logic mon_rx_a,
  input wire logic mon_rx_b,
  output logic mon_tx_a,
  output logic mon_tx_b,
  output logic wrap_primary_to_backup,
  output logic wrap_backup_to_primary,
  output logic signal_loss,
  output logic alarm_led,
  output logic alarm_relay,
  output logic irq
);
  import ring_node_pkg::*;

  if (LOSS_CYCLES <= 2 * MON_HALF_CYC || GEN_PULSE >= GEN_PERIOD ||
      FLASH_CYCLES < 2 || GEN_PULSE < 1) begin : g_chk
    $error("ring_node: timing parameters out of range");
  end

  localparam int unsigned FW = $clog2(FLASH_CYCLES + 1);
  localparam int unsigned GW = $clog2(GEN_PERIOD + 1);
  localparam int unsigned MW = $clog2(MON_HALF_CYC + 1);
  localparam logic [FW-1:0] FLASH_LIM = FW'(FLASH_CYCLES - 1);
  localparam logic [GW-1:0] GEN_LIM = GW'(GEN_PERIOD - 1);
  localparam logic [GW-1:0] GEN_LOW = GW'(GEN_PULSE);
  localparam logic [MW-1:0] MON_LIM = MW'(MON_HALF_CYC - 1);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [NSYNC-1:0] sy1_q;
  logic [NSYNC-1:0] sy2_q;
  wire [NSYNC-1:0] pins = {mon_rx_b, mon_rx_a, sig_det_b, sig_det_a,
                           opt_rx_b, opt_rx_a, rtu_rxd, host_rxd};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy1_q <= SYNC_RESET;
      sy2_q <= SYNC_RESET;
    end else begin
      sy1_q <= pins;
      sy2_q <= sy1_q;
    end
  end
  wire host_s = sy2_q[PIN_HOST];
  wire rtu_s = sy2_q[PIN_RTU];
  wire rx_a = sy2_q[PIN_RX_A];
  wire rx_b = sy2_q[PIN_RX_B];

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_q;
  wire master = ctrl_q[CTRL_MASTER];
  wire single = ctrl_q[CTRL_SINGLE];
  wire loop_en = ctrl_q[CTRL_LOOP];
  wire gen_en = ctrl_q[CTRL_GEN];
  wire alm_dis = ctrl_q[CTRL_ALM_DIS];

  // backup signal loss is ignored on a single ring; its monitor input is still relayed
  wire loss_a = ~sy2_q[PIN_SD_A];
  wire loss_b = ~sy2_q[PIN_SD_B] & ~single;

  // ----------------------------------------------------------------
  // loop monitors
  // ----------------------------------------------------------------
  logic [1:0] mon_alive;
  logic [1:0] mon_in;
  assign mon_in = {sy2_q[PIN_MON_B], sy2_q[PIN_MON_A]};
  for (genvar r = 0; r < 2; r++) begin : g_mon
    activity_watch #(.LIMIT(LOSS_CYCLES)) u_watch (
      .pclk(pclk),
      .presetn(presetn),
      .sig(mon_in[r]),
      .alive(mon_alive[r])
    );
  end
  wire loop_alarm_a = master & ~mon_alive[0];
  wire loop_alarm_b = master & ~single & ~mon_alive[1];
  logic [MW-1:0] mon_cnt_q;
  logic mon_gen_q;
  logic [1:0] mon_tx_q;
  wire mon_wrap = (mon_cnt_q == MON_LIM);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_cnt_q <= '0;
      mon_gen_q <= 1'b0;
      mon_tx_q <= 2'b00;
    end else begin
      mon_cnt_q <= mon_wrap ? '0 : mon_cnt_q + 1'b1;
      mon_gen_q <= mon_wrap ? ~mon_gen_q : mon_gen_q;
      mon_tx_q <= master ? {mon_gen_q, mon_gen_q} : mon_in;
    end
  end
  assign mon_tx_a = mon_tx_q[0];
  assign mon_tx_b = mon_tx_q[1];

  // ----------------------------------------------------------------
  // break detection and wrap state
  // ----------------------------------------------------------------
  wrap_state_t wrap_q;
  wrap_state_t wrap_d;

  always_comb begin
    case ({master | single, loss_a, loss_b})
      3'b000: wrap_d = WRAP_NONE;
      3'b001: wrap_d = WRAP_TO_BAK;
      3'b010: wrap_d = WRAP_TO_PRI;
      3'b011: wrap_d = WRAP_ISO;
      default: wrap_d = WRAP_NONE;
    endcase
  end

  // fault classes: primary only, backup only, both, monitor only
  wire [3:0] fault_d = {~loss_a & ~loss_b & (loop_alarm_a | loop_alarm_b),
                        loss_a & loss_b, ~loss_a & loss_b,
                        loss_a & ~loss_b};
  logic [3:0] fault_q;

  // ----------------------------------------------------------------
  // data paths
  // ----------------------------------------------------------------
  logic [GW-1:0] gen_cnt_q;
  wire gen_bit = (gen_cnt_q >= GEN_LOW); // idle high, low pulse
  wire src = gen_en ? gen_bit : host_s;
  logic ring_in;
  logic tx_a_d;
  logic tx_b_d;
  always_comb begin
    ring_in = rx_a;
    tx_a_d = rx_a & rtu_s;
    tx_b_d = single ? 1'b1 : rx_b & rtu_s;
    case (wrap_q)
      WRAP_NONE: ring_in = rx_a;
      WRAP_TO_BAK: tx_b_d = rx_a & rtu_s;
      WRAP_TO_PRI: begin
        ring_in = rx_b;
        tx_a_d = rx_b & rtu_s;
        tx_b_d = rx_b & rtu_s;
      end
      WRAP_ISO: begin
        ring_in = 1'b1;
        tx_a_d = rtu_s;
        tx_b_d = rtu_s;
      end
      default: ring_in = rx_a;
    endcase
  end

  wire resp_in = (loss_a & ~single) ? rx_b : rx_a;
  wire host_d = loop_en ? src : resp_in;
  wire rtu_d = gen_en ? gen_bit : loop_en ? rtu_s : ring_in;
  wire opt_a_d = master ? src : tx_a_d;
  wire opt_b_d = master ? (single ? 1'b1 : src) : tx_b_d;

  logic [3:0] line_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_q <= 4'hf;
      gen_cnt_q <= '0;
    end else begin
      line_q <= {opt_b_d, opt_a_d, rtu_d, host_d};
      gen_cnt_q <= (gen_cnt_q == GEN_LIM) ? '0 : gen_cnt_q + 1'b1;
    end
  end
  assign host_txd = line_q[0];
  assign rtu_txd = line_q[1];
  assign opt_tx_a = line_q[2];
  assign opt_tx_b = line_q[3];

  // ----------------------------------------------------------------
  // indications and alarm
  // ----------------------------------------------------------------
  logic [FW-1:0] flash_cnt_q;
  logic flash_q;
  logic [2:0] ind_q;
  logic alarm_q;
  logic alarm_led_q;
  logic relay_q;
  wire alarm_d = loop_alarm_a | loop_alarm_b | loss_a | loss_b |
                 loop_en | gen_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_cnt_q <= '0;
      flash_q <= 1'b0;
      wrap_q <= WRAP_NONE;
      fault_q <= 4'h0;
      ind_q <= 3'b000;
      alarm_q <= 1'b0;
      alarm_led_q <= 1'b0;
      relay_q <= 1'b0;
    end else begin
      flash_cnt_q <= (flash_cnt_q == FLASH_LIM) ? '0 : flash_cnt_q + 1'b1;
      flash_q <= (flash_cnt_q == FLASH_LIM) ? ~flash_q : flash_q;
      wrap_q <= wrap_d;
      fault_q <= fault_d;
      ind_q <= {loss_a | loss_b, wrap_d == WRAP_TO_PRI || wrap_d == WRAP_ISO,
                wrap_d == WRAP_TO_BAK || wrap_d == WRAP_ISO};
      alarm_q <= alarm_d;
      alarm_led_q <= alarm_d & flash_q;
      relay_q <= alarm_d & ~alm_dis;
    end
  end
  assign wrap_primary_to_backup = ind_q[0];
  assign wrap_backup_to_primary = ind_q[1];
  assign signal_loss = ind_q[2];
  assign alarm_led = alarm_led_q;
  assign alarm_relay = relay_q;

  // ----------------------------------------------------------------
  // register bus and interrupts
  // ----------------------------------------------------------------
  wire [STAT_W-1:0] status = {fault_q, alarm_q, loop_alarm_b, loop_alarm_a,
                              loss_b, loss_a, ind_q[1], ind_q[0]};
  logic [INT_W-1:0] int_stat_q;
  logic [INT_W-1:0] int_mask_q;
  logic [INT_W-1:0] ev_prev_q;
  logic [31:0] rdata_q;
  wire [INT_W-1:0] ev_lvl = {loop_alarm_b, loop_alarm_a, ind_q[2],
                             ind_q[1], ind_q[0]};
  wire [INT_W-1:0] ev_rise = ev_lvl & ~ev_prev_q;
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire hit_ctrl = (paddr == ADDR_CTRL);
  wire hit_stat = (paddr == ADDR_STATUS);
  wire hit_int = (paddr == ADDR_INT_STAT);
  wire hit_mask = (paddr == ADDR_INT_MASK);
  wire mapped = hit_ctrl | hit_stat | hit_int | hit_mask;
  wire rd_clr = access & ~pwrite & hit_int;
  wire [INT_W-1:0] clr_bits = rd_clr ? rdata_q[INT_W-1:0] : '0;
  wire [31:0] rd_mux =
    hit_ctrl ? {{(32-CTRL_W){1'b0}}, ctrl_q} :
    hit_stat ? {{(32-STAT_W){1'b0}}, status} :
    hit_int ? {{(32-INT_W){1'b0}}, int_stat_q} :
    hit_mask ? {{(32-INT_W){1'b0}}, int_mask_q} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      int_mask_q <= INT_RESET;
      int_stat_q <= INT_RESET;
      ev_prev_q <= INT_RESET;
      rdata_q <= 32'h0000_0000;
    end else begin
      if (access && pwrite && hit_ctrl)
        ctrl_q <= pwdata[CTRL_W-1:0];
      if (access && pwrite && hit_mask)
        int_mask_q <= pwdata[INT_W-1:0];
      int_stat_q <= (int_stat_q & ~clr_bits) | ev_rise; // set wins
      ev_prev_q <= ev_lvl;
      if (setup && !pwrite)
        rdata_q <= rd_mux;
    end
  end

  assign prdata = rdata_q;
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign irq = |(int_stat_q & int_mask_q);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire slave_n = !master && !loop_en && !gen_en;
  a_master_dual_tx: assert property (
    (master && !single && $stable(ctrl_q)) |=> (opt_tx_a == opt_tx_b))
    else $error("master rings differ");
  a_slave_bcast_fwd: assert property (
    (slave_n && wrap_q == WRAP_NONE) |=> (rtu_txd == $past(rx_a)))
    else $error("broadcast not forwarded");
  a_slave_resp_relay: assert property (
    (!master && wrap_q == WRAP_NONE) |=> (opt_tx_a == $past(rx_a & rtu_s)))
    else $error("response not relayed");
  a_wrap_bak_path: assert property (
    (!master && wrap_q == WRAP_TO_BAK) |=> (opt_tx_b == $past(rx_a & rtu_s)))
    else $error("primary to backup wrap wrong");
  a_wrap_pri_path: assert property (
    (!master && wrap_q == WRAP_TO_PRI) |=> (opt_tx_a == $past(rx_b & rtu_s)))
    else $error("backup to primary wrap wrong");

  sequence s_break_b;
    !master && !single && loss_b && !loss_a;
  endsequence
  sequence s_wrapped;
    wrap_q == WRAP_TO_BAK && wrap_primary_to_backup;
  endsequence
  a_break_wraps: assert property (s_break_b |=> s_wrapped)
    else $error("break not wrapped");
  a_single_no_wrap: assert property (
    single[*2] |-> (wrap_q == WRAP_NONE) && !wrap_backup_to_primary)
    else $error("single ring wrapped");
  a_wrap_release: assert property (
    (wrap_q != WRAP_NONE && !loss_a && !loss_b) |=> !signal_loss &&
    (wrap_q == WRAP_NONE))
    else $error("wrap not released");
  a_mon_relay: assert property (
    (!master)[*2] |-> (mon_tx_b == $past(mon_in[1])))
    else $error("monitor not relayed");
  a_alarm_relay: assert property (
    (loop_alarm_a && !alm_dis) |=> alarm_relay)
    else $error("alarm relay idle");
  a_int_set_wins: assert property (
    (|ev_rise) |=> ((int_stat_q & $past(ev_rise)) == $past(ev_rise)))
    else $error("event lost");
endmodule

// ==== ring_far_side.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// rest of the ring seen from one node
// ------------------------------------------------------------
module ring_far_side (
  input wire logic pclk,
  input wire logic mon_tx_a,
  input wire logic mon_tx_b,
  input wire logic cut_a,
  input wire logic cut_b,
  input wire logic inj_a,
  input wire logic inj_b,
  output logic opt_rx_a,
  output logic opt_rx_b,
  output logic sig_det_a,
  output logic sig_det_b,
  output logic mon_rx_a,
  output logic mon_rx_b
);
  logic [3:0] dly_a = 4'h0;
  logic [3:0] dly_b = 4'h0;
  logic last_a = 1'b0;
  logic last_b = 1'b0;
  logic tgl = 1'b0;
  // monitor comes back round the ring; a cut span shows the inverse of the last level, held steady
  always @(posedge pclk) begin
    dly_a <= {dly_a[2:0], mon_tx_a};
    dly_b <= {dly_b[2:0], mon_tx_b};
    last_a <= cut_a ? last_a : dly_a[3];
    last_b <= cut_b ? last_b : dly_b[3];
    tgl <= ~tgl;
  end
  assign mon_rx_a = cut_a ? ~last_a : last_a;
  assign mon_rx_b = cut_b ? ~last_b : last_b;
  // dead fibre carries noise, never a clean idle
  assign opt_rx_a = cut_a ? tgl : inj_a;
  assign opt_rx_b = cut_b ? tgl : inj_b;
  assign sig_det_a = ~cut_a;
  assign sig_det_b = ~cut_b;
endmodule

// ==== self_healing_ring_node_bench.sv ====
`timescale 1ns/10ps
module self_healing_ring_node_bench;
  import ring_node_pkg::*;
  localparam int LOSS = 300;
  localparam int GP = 64;
  localparam int GPU = 8;
  localparam int HTX = 0, RTX = 1, TXA = 2, TXB = 3, P2B = 4, B2P = 5;
  localparam int LOS = 6, RLY = 7, IRQ = 8, LED = 9;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, host_txd, rtu_txd, opt_tx_a, opt_tx_b;
  logic host_rxd = 1'b1, rtu_rxd = 1'b1;
  logic cut_a = 1'b0, cut_b = 1'b0, inj_a = 1'b1, inj_b = 1'b1;
  logic opt_rx_a, opt_rx_b, sig_det_a, sig_det_b;
  logic mon_rx_a, mon_rx_b, mon_tx_a, mon_tx_b;
  logic w_p2b, w_b2p, signal_loss, alarm_led, alarm_relay, irq;
  logic [9:0] obs;
  int n_mismatch = 0, checks_done = 0, cyc = 0;

  assign obs = {alarm_led, irq, alarm_relay, signal_loss, w_b2p, w_p2b,
                opt_tx_b, opt_tx_a, rtu_txd, host_txd};

  ring_node #(.LOSS_CYCLES(LOSS), .FLASH_CYCLES(8), .GEN_PERIOD(GP),
    .GEN_PULSE(GPU)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_rxd(host_rxd), .host_txd(host_txd), .rtu_rxd(rtu_rxd),
    .rtu_txd(rtu_txd), .opt_rx_a(opt_rx_a), .opt_rx_b(opt_rx_b),
    .sig_det_a(sig_det_a), .sig_det_b(sig_det_b), .opt_tx_a(opt_tx_a),
    .opt_tx_b(opt_tx_b), .mon_rx_a(mon_rx_a), .mon_rx_b(mon_rx_b),
    .mon_tx_a(mon_tx_a), .mon_tx_b(mon_tx_b),
    .wrap_primary_to_backup(w_p2b), .wrap_backup_to_primary(w_b2p),
    .signal_loss(signal_loss), .alarm_led(alarm_led),
    .alarm_relay(alarm_relay), .irq(irq));

  ring_far_side far (.pclk(pclk), .mon_tx_a(mon_tx_a), .mon_tx_b(mon_tx_b),
    .cut_a(cut_a), .cut_b(cut_b), .inj_a(inj_a), .inj_b(inj_b),
    .opt_rx_a(opt_rx_a), .opt_rx_b(opt_rx_b), .sig_det_a(sig_det_a),
    .sig_det_b(sig_det_b), .mon_rx_a(mon_rx_a), .mon_rx_b(mon_rx_b));

  always #5 pclk = ~pclk;

  // ------------------------------------------------------------
  // checking and bus helpers
  // ------------------------------------------------------------
  task automatic tally_and_finish;
    if (n_mismatch == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic wait_bit(input int idx, input logic v, input int lim);
    int n = 0;
    while (obs[idx] !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk1(obs[idx], v);
  endtask

  task automatic hold(input int idx, input logic v, input int c);
    logic bad = 1'b0;
    repeat (c) begin
      @(posedge pclk);
      if (obs[idx] !== v) bad = 1'b1;
    end
    chk1(bad, 1'b0);
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] d;
    logic e;
    rd(ADDR_CTRL, d);
    chk(d, 32'h0);
    rd(ADDR_INT_MASK, d);
    chk(d, 32'h0);
    apb(1'b0, 8'h10, 32'h0, d, e);
    chk({d[30:0], e}, 32'h1);
  endtask

  task automatic t_master;
    wr(ADDR_CTRL, 32'h1);
    host_rxd <= 1'b0;
    inj_a <= 1'b0; // one responder at a time
    wait_bit(TXA, 1'b0, 8);
    chk1(obs[TXB], 1'b0);
    chk1(obs[HTX], 1'b0);
    host_rxd <= 1'b1;
    inj_a <= 1'b1;
    wait_bit(HTX, 1'b1, 8);
    hold(HTX, 1'b1, 6);
    inj_b <= 1'b0;
    hold(HTX, 1'b1, 8);
    cut_a <= 1'b1;
    wait_bit(HTX, 1'b0, 8);
    inj_b <= 1'b1;
    cut_a <= 1'b0;
    wait_bit(HTX, 1'b1, 8);
  endtask

  task automatic t_monitor;
    logic [31:0] d;
    logic l;
    repeat (8) @(posedge pclk);
    hold(RLY, 1'b0, 400);
    rd(ADDR_INT_STAT, d);
    cut_b <= 1'b1;
    hold(IRQ, 1'b0, 20);
    wr(ADDR_INT_MASK, 32'h1 << INT_LOOP_B);
    wait_bit(IRQ, 1'b1, LOSS + 250);
    rd(ADDR_STATUS, d);
    chk({30'h0, d[ST_LOOP_B], d[ST_LOOP_A]}, 32'h2);
    chk1(obs[RLY], 1'b1);
    wr(ADDR_CTRL, 32'h1 | (32'h1 << CTRL_ALM_DIS));
    wait_bit(RLY, 1'b0, 4);
    wr(ADDR_CTRL, 32'h1);
    l = obs[LED];
    wait_bit(LED, ~l, 20);
    wait_bit(LED, l, 20);
    rd(ADDR_INT_STAT, d);
    chk1(d[INT_LOOP_B], 1'b1);
    wait_bit(IRQ, 1'b0, 2);
    cut_b <= 1'b0;
    wr(ADDR_INT_MASK, 32'h0);
  endtask

  task automatic t_slave;
    wr(ADDR_CTRL, 32'h0);
    inj_a <= 1'b0;
    wait_bit(TXA, 1'b0, 8);
    chk1(obs[RTX], 1'b0);
    inj_a <= 1'b1;
    wait_bit(TXA, 1'b1, 8);
    rtu_rxd <= 1'b0;
    wait_bit(TXA, 1'b0, 8);
    rtu_rxd <= 1'b1;
    wait_bit(TXA, 1'b1, 8);
  endtask

  task automatic t_wrap;
    logic [31:0] d;
    cut_b <= 1'b1;
    wait_bit(P2B, 1'b1, 8);
    chk1(obs[B2P], 1'b0);
    chk1(obs[LOS], 1'b1);
    inj_a <= 1'b0;
    wait_bit(TXB, 1'b0, 8);
    inj_a <= 1'b1;
    cut_b <= 1'b0;
    wait_bit(P2B, 1'b0, 8);
    cut_a <= 1'b1;
    wait_bit(B2P, 1'b1, 8);
    chk1(obs[P2B], 1'b0);
    inj_b <= 1'b0;
    wait_bit(TXA, 1'b0, 8);
    inj_b <= 1'b1;
    cut_b <= 1'b1;
    wait_bit(P2B, 1'b1, 8);
    chk1(obs[B2P], 1'b1);
    rd(ADDR_STATUS, d);
    chk({28'h0, d[ST_FAULT+3:ST_FAULT]}, 32'h4);
    cut_a <= 1'b0;
    cut_b <= 1'b0;
    wait_bit(B2P, 1'b0, 8);
    wait_bit(P2B, 1'b0, 8);
    wait_bit(LOS, 1'b0, 8);
  endtask

  task automatic t_single;
    wr(ADDR_CTRL, 32'h1 << CTRL_SINGLE);
    cut_b <= 1'b1;
    hold(P2B, 1'b0, 12);
    cut_b <= 1'b0;
    cut_a <= 1'b1;
    hold(B2P, 1'b0, 12);
    cut_a <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  task automatic t_diag;
    wr(ADDR_CTRL, 32'h1 | (32'h1 << CTRL_LOOP));
    host_rxd <= 1'b0;
    wait_bit(HTX, 1'b0, 8);
    host_rxd <= 1'b1;
    wait_bit(HTX, 1'b1, 8);
    wr(ADDR_CTRL, 32'h1 | (32'h1 << CTRL_GEN));
    wait_bit(TXA, 1'b0, GP + 8);
    wait_bit(TXA, 1'b1, GPU + 8);
    wait_bit(RTX, 1'b0, GP + 8);
    wait_bit(RLY, 1'b1, 8);
    wr(ADDR_CTRL, 32'h0);
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_master();
    t_monitor();
    t_slave();
    t_wrap();
    t_single();
    t_diag();
    tally_and_finish();
  end
endmodule
